// >>> hdl/shift_unit_pkg.sv
// shared constants, encodings and types of the alu shift unit
package shift_unit_pkg;

   localparam int DATA_W = 16;
   localparam int PRODUCT_W = 32;
   localparam int REG_COUNT = 8;
   localparam int SEL_W = 3;
   localparam int IMM_W = 4;
   localparam int COUNT_W = 16;

   // field positions inside the instruction word
   localparam int IMM_LSB = 3;
   localparam int AMOUNT_SEL_LSB = 3;
   localparam int TARGET_SEL_LSB = 0;

   // opcode patterns, upper fields and low tail
   localparam logic [2:0] PRODUCT_TAIL = 3'h5;
   localparam logic [8:0] OP_PRODUCT_LEFT_IMM = 9'h071;
   localparam logic [9:0] OP_PRODUCT_RIGHT_REG = 10'h0E4;
   localparam logic [8:0] OP_PRODUCT_RIGHT_IMM = 9'h070;
   localparam logic [12:0] OP_BYTE_LEFT = 13'h05DF;
   localparam logic [12:0] OP_BYTE_RIGHT = 13'h05DE;
   localparam logic [9:0] OP_LEFT_REG = 10'h0BA;
   localparam logic [8:0] OP_LEFT_IMM = 9'h05A;
   localparam logic [9:0] OP_SIGNED_LEFT_REG = 10'h0B8;
   localparam logic [8:0] OP_SIGNED_LEFT_IMM = 9'h058;
   localparam logic [9:0] OP_RIGHT_REG = 10'h0B9;
   localparam logic [8:0] OP_RIGHT_IMM = 9'h059;
   localparam logic [9:0] OP_SIGNED_RIGHT_REG = 10'h0B7;
   localparam logic [8:0] OP_SIGNED_RIGHT_IMM = 9'h04F;

   // cycles of the fixed byte shift and its distance
   localparam logic [COUNT_W-1:0] BYTE_CYCLES = 16'h0001;
   localparam int BYTE_DIST = 8;

   // values after reset
   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [PRODUCT_W-1:0] WORK_RESET = 32'h0000_0000;

   typedef logic [REG_COUNT-1:0][DATA_W-1:0] alu_regs_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } state_t;

   typedef struct packed {
      logic valid;
      logic product;
      logic left;
      logic signed_op;
      logic byte_shift;
      logic use_imm;
      logic flag_overflow;
      logic [IMM_W-1:0] imm;
      logic [SEL_W-1:0] amount_sel;
      logic [SEL_W-1:0] target_sel;
   } shift_op_t;

   typedef struct packed {
      logic en;
      logic [SEL_W-1:0] sel;
      logic [DATA_W-1:0] data;
   } reg_write_t;

   typedef struct packed {
      logic en;
      logic [DATA_W-1:0] high_half;
      logic [DATA_W-1:0] low_half;
   } product_write_t;

endpackage

// >>> hdl/shift_decode.sv
// decoder of the shift instruction group
`timescale 1ns/1ps
module shift_decode (
   input wire logic [15:0] instr,
   output shift_unit_pkg::shift_op_t op
);
   import shift_unit_pkg::*;

   wire tail_ok = instr[2:0] == PRODUCT_TAIL;
   wire is_p_left_imm = instr[15:7] == OP_PRODUCT_LEFT_IMM && tail_ok; // RULE_02
   wire is_p_right_reg = instr[15:6] == OP_PRODUCT_RIGHT_REG && tail_ok; // RULE_03
   wire is_p_right_imm = instr[15:7] == OP_PRODUCT_RIGHT_IMM && tail_ok; // RULE_04
   wire is_byte_left = instr[15:3] == OP_BYTE_LEFT; // RULE_06
   wire is_byte_right = instr[15:3] == OP_BYTE_RIGHT; // RULE_07
   wire is_left_reg = instr[15:6] == OP_LEFT_REG; // RULE_11
   wire is_left_imm = instr[15:7] == OP_LEFT_IMM; // RULE_12
   wire is_s_left_reg = instr[15:6] == OP_SIGNED_LEFT_REG; // RULE_13
   wire is_s_left_imm = instr[15:7] == OP_SIGNED_LEFT_IMM; // RULE_14
   wire is_right_reg = instr[15:6] == OP_RIGHT_REG; // RULE_15
   wire is_right_imm = instr[15:7] == OP_RIGHT_IMM; // RULE_16
   wire is_s_right_reg = instr[15:6] == OP_SIGNED_RIGHT_REG; // RULE_17
   wire is_s_right_imm = instr[15:7] == OP_SIGNED_RIGHT_IMM; // RULE_18

   wire is_product = is_p_left_imm | is_p_right_reg | is_p_right_imm;
   wire is_byte = is_byte_left | is_byte_right;
   wire is_left = is_p_left_imm | is_byte_left | is_left_reg | is_left_imm | is_s_left_reg | is_s_left_imm;
   wire is_signed = is_s_left_reg | is_s_left_imm | is_s_right_reg | is_s_right_imm;
   wire is_imm = is_p_left_imm | is_p_right_imm | is_left_imm | is_s_left_imm | is_right_imm | is_s_right_imm;
   wire is_narrow = is_byte | is_left_reg | is_left_imm | is_s_left_reg | is_s_left_imm | is_right_reg
      | is_right_imm | is_s_right_reg | is_s_right_imm;

   assign op.valid = is_product | is_narrow;
   assign op.product = is_product;
   assign op.left = is_left;
   assign op.signed_op = is_signed;
   assign op.byte_shift = is_byte;
   assign op.use_imm = is_imm;
   assign op.flag_overflow = is_left | is_s_right_imm; // RULE_09 RULE_10
   assign op.imm = instr[IMM_LSB +: IMM_W]; // RULE_19
   assign op.amount_sel = instr[AMOUNT_SEL_LSB +: SEL_W];
   assign op.target_sel = instr[TARGET_SEL_LSB +: SEL_W]; // RULE_21
endmodule // shift_decode

// >>> hdl/shift_step.sv
// one-position shift step with shift-out and flag hit
`timescale 1ns/1ps
module shift_step #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] data_in,
   input wire logic left,
   input wire logic signed_op,
   output logic [WIDTH-1:0] data_out,
   output logic out_bit,
   output logic flag_hit
);
   wire sign = data_in[WIDTH-1];
   wire [WIDTH-1:0] left_plain = {data_in[WIDTH-2:0], 1'b0}; // RULE_20
   wire [WIDTH-1:0] left_signed = {sign, data_in[WIDTH-3:0], 1'b0}; // RULE_08
   wire [WIDTH-1:0] right_plain = {1'b0, data_in[WIDTH-1:1]}; // RULE_20
   wire [WIDTH-1:0] right_signed = {sign, sign, data_in[WIDTH-2:1]}; // RULE_08

   // signed left loses the bit below the sign; overflow when it differs from the sign
   wire left_out = signed_op ? data_in[WIDTH-2] : data_in[WIDTH-1];
   wire left_hit = signed_op ? (data_in[WIDTH-2] ^ sign) : data_in[WIDTH-1];

   assign data_out = left ? (signed_op ? left_signed : left_plain) : (signed_op ? right_signed : right_plain);
   assign out_bit = left ? left_out : data_in[0]; // RULE_20
   assign flag_hit = left ? left_hit : data_in[0];
endmodule // shift_step

// >>> hdl/alu_shift_unit.sv
// shift section of the microcore alu: register file, product halves and flags
//
// Functional notes
// RULE_01: product operand is high half over low half; product shifts write both back.
// RULE_02: immediate product left shift moves the 32-bit product left by the immediate.
// RULE_03: register product right shift moves the product right by a register value.
// RULE_04: immediate product right shift moves the product right by the immediate.
// RULE_05: variable shifts take as many core cycles as the shift amount.
// RULE_06: byte left shift moves a register left by 8 in one cycle.
// RULE_07: byte right shift moves a register right by 8 in one cycle.
// RULE_08: signed shifts keep the sign bit unchanged throughout.
// RULE_09: every left shift updates shift-out bit and overflow flags.
// RULE_10: right shifts update shift-out and precision loss; signed immediate right updates overflow.
// RULE_11: register left shift moves target left by the amount register.
// RULE_12: immediate left shift moves target left by the immediate.
// RULE_13: signed register left shift keeps the sign bit.
// RULE_14: signed immediate left shift keeps the sign bit.
// RULE_15: register right shift moves target right by the amount register.
// RULE_16: immediate right shift moves target right by the immediate.
// RULE_17: signed register right shift keeps the sign bit.
// RULE_18: signed immediate right shift keeps the sign bit.
// RULE_19: immediate amounts come from a 4-bit field, 0 to 15.
// RULE_20: unsigned shifts fill zeros; shift-out flag holds the last bit out.
// RULE_21: select fields index the register subset; result returns to its source.
// RULE_22: completion is reported and fetch stalled until the count has elapsed.
`timescale 1ns/1ps
module alu_shift_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire shift_unit_pkg::reg_write_t reg_wr,
   input wire shift_unit_pkg::product_write_t product_wr,
   output logic instr_ready,
   output logic stall_fetch,
   output logic op_done,
   output shift_unit_pkg::alu_regs_t alu_general_register_subset,
   output logic [15:0] product_high_half,
   output logic [15:0] product_low_half,
   output logic shift_out_bit_flag,
   output logic shift_overflow_flag,
   output logic precision_loss_flag
);
   import shift_unit_pkg::*;

   state_t state;
   state_t next_state;
   shift_op_t dec;
   shift_op_t op;
   logic [PRODUCT_W-1:0] work;
   logic [COUNT_W-1:0] count;
   logic out_acc;
   logic hit_acc;

   // decode of the incoming word
   shift_decode u_decode (
      .instr(instr),
      .op(dec)
   );

   wire in_idle = state == ST_IDLE;
   wire in_run = state == ST_RUN;
   wire in_done = state == ST_DONE;

   // words that are not shifts are not taken; the sequencer routes them elsewhere
   wire accept = instr_valid && in_idle && dec.valid;

   // amount and operand as seen at the accept edge
   wire [COUNT_W-1:0] imm_amount = {{(COUNT_W-IMM_W){1'b0}}, dec.imm}; // RULE_19
   wire [COUNT_W-1:0] reg_amount = alu_general_register_subset[dec.amount_sel];
   wire [COUNT_W-1:0] var_amount = dec.use_imm ? imm_amount : reg_amount;
   wire [COUNT_W-1:0] start_count = dec.byte_shift ? BYTE_CYCLES : var_amount; // RULE_05
   wire [PRODUCT_W-1:0] product_operand = {product_high_half, product_low_half}; // RULE_01
   wire [PRODUCT_W-1:0] narrow_operand = {16'h0000, alu_general_register_subset[dec.target_sel]}; // RULE_21
   wire [PRODUCT_W-1:0] start_work = dec.product ? product_operand : narrow_operand;

   // one-bit steps for the 16-bit registers and for the product
   logic [DATA_W-1:0] narrow_next;
   logic narrow_out;
   logic narrow_hit;
   logic [PRODUCT_W-1:0] wide_next;
   logic wide_out;
   logic wide_hit;

   shift_step #(
      .WIDTH(DATA_W)
   ) u_narrow_step (
      .data_in(work[DATA_W-1:0]),
      .left(op.left),
      .signed_op(op.signed_op),
      .data_out(narrow_next),
      .out_bit(narrow_out),
      .flag_hit(narrow_hit)
   );

   // product shifts have no signed form
   shift_step #(
      .WIDTH(PRODUCT_W)
   ) u_wide_step (
      .data_in(work),
      .left(op.left),
      .signed_op(1'b0),
      .data_out(wide_next),
      .out_bit(wide_out),
      .flag_hit(wide_hit)
   );

   // byte shift moves all eight positions in its single cycle
   wire [DATA_W-1:0] byte_left = {work[DATA_W-BYTE_DIST-1:0], 8'h00}; // RULE_06
   wire [DATA_W-1:0] byte_right = {8'h00, work[DATA_W-1:BYTE_DIST]}; // RULE_07
   wire [DATA_W-1:0] byte_next = op.left ? byte_left : byte_right;
   wire byte_out = op.left ? work[BYTE_DIST] : work[BYTE_DIST-1];
   wire byte_hit = op.left ? (|work[DATA_W-1:BYTE_DIST]) : (|work[BYTE_DIST-1:0]);

   // step selection
   wire [PRODUCT_W-1:0] step_narrow = {16'h0000, op.byte_shift ? byte_next : narrow_next};
   wire [PRODUCT_W-1:0] step_next = op.product ? wide_next : step_narrow;
   wire step_out = op.product ? wide_out : (op.byte_shift ? byte_out : narrow_out);
   wire step_hit = op.product ? wide_hit : (op.byte_shift ? byte_hit : narrow_hit);
   wire last_step = count == BYTE_CYCLES;

   // writeback targets of the finishing shift
   wire wb_product = in_done && op.product; // RULE_01
   wire wb_narrow = in_done && !op.product; // RULE_21

   // handshake toward the sequencer
   assign instr_ready = in_idle;
   assign stall_fetch = !in_idle; // RULE_22
   assign op_done = in_done; // RULE_22

   // next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               // a zero amount skips the run phase and finishes at once
               next_state = (start_count == COUNT_RESET) ? ST_DONE : ST_RUN;
            end
         end
         ST_RUN: begin
            if (last_step) begin
               next_state = ST_DONE; // RULE_05
            end
         end
         ST_DONE: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // captured instruction stays stable for the whole shift
   always_ff @(posedge clk) begin
      if (rst) begin
         op <= '0;
      end else if (accept) begin
         op <= dec;
      end
   end

   // working copy and cycle counter
   always_ff @(posedge clk) begin
      if (rst) begin
         work <= WORK_RESET;
         count <= COUNT_RESET;
      end else if (accept) begin
         work <= start_work;
         count <= start_count; // RULE_05
      end else if (in_run) begin
         work <= step_next; // RULE_02 RULE_03 RULE_04 RULE_11 RULE_12 RULE_15 RULE_16
         count <= count - 16'h0001; // RULE_05
      end
   end

   // flag accumulators: last bit out, and any hit along the way
   always_ff @(posedge clk) begin
      if (rst) begin
         out_acc <= 1'b0;
         hit_acc <= 1'b0;
      end else if (accept) begin
         out_acc <= 1'b0;
         hit_acc <= 1'b0;
      end else if (in_run) begin
         out_acc <= step_out; // RULE_20
         hit_acc <= hit_acc | step_hit;
      end
   end

   // condition flags are loaded only when a shift finishes
   always_ff @(posedge clk) begin
      if (rst) begin
         shift_out_bit_flag <= 1'b0;
         shift_overflow_flag <= 1'b0;
         precision_loss_flag <= 1'b0;
      end else if (in_done) begin
         shift_out_bit_flag <= out_acc; // RULE_09 RULE_10
         if (op.flag_overflow) begin
            shift_overflow_flag <= hit_acc; // RULE_09 RULE_10
         end else begin
            precision_loss_flag <= hit_acc; // RULE_10
         end
      end
   end

   // register file: the finishing shift wins over an outside write to the same register
   always_ff @(posedge clk) begin
      if (rst) begin
         alu_general_register_subset <= '0;
      end else begin
         if (reg_wr.en) begin
            alu_general_register_subset[reg_wr.sel] <= reg_wr.data;
         end
         if (wb_narrow) begin
            alu_general_register_subset[op.target_sel] <= work[DATA_W-1:0]; // RULE_21 RULE_08 RULE_13 RULE_14 RULE_17 RULE_18
         end
      end
   end

   // product halves: loaded by the multiplier, both rewritten by product shifts
   always_ff @(posedge clk) begin
      if (rst) begin
         product_high_half <= REG_RESET;
         product_low_half <= REG_RESET;
      end else if (wb_product) begin
         product_high_half <= work[PRODUCT_W-1:DATA_W]; // RULE_01
         product_low_half <= work[DATA_W-1:0]; // RULE_01
      end else if (product_wr.en) begin
         product_high_half <= product_wr.high_half;
         product_low_half <= product_wr.low_half;
      end
   end

endmodule // alu_shift_unit

// >>> sim/shift_unit_asserts.sv
// concurrent checks on the ports of the alu shift unit
`timescale 1ns/1ps
module shift_unit_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire shift_unit_pkg::reg_write_t reg_wr,
   input wire shift_unit_pkg::product_write_t product_wr,
   input wire logic instr_ready,
   input wire logic stall_fetch,
   input wire logic op_done,
   input wire shift_unit_pkg::alu_regs_t alu_general_register_subset,
   input wire logic [15:0] product_high_half,
   input wire logic [15:0] product_low_half,
   input wire logic shift_out_bit_flag,
   input wire logic shift_overflow_flag,
   input wire logic precision_loss_flag
);
   import shift_unit_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire take = instr_valid && instr_ready;
   wire [8:0] top9 = instr[15:7];
   wire prod_imm = (top9 == OP_PRODUCT_LEFT_IMM || top9 == OP_PRODUCT_RIGHT_IMM) && instr[2:0] == PRODUCT_TAIL;
   wire imm_take = take && (prod_imm || top9 == OP_LEFT_IMM || top9 == OP_RIGHT_IMM ||
      top9 == OP_SIGNED_LEFT_IMM || top9 == OP_SIGNED_RIGHT_IMM);
   wire [2:0] flags = {shift_out_bit_flag, shift_overflow_flag, precision_loss_flag};
   logic [7:0] cnt;
   logic [3:0] amt;
   logic timed;
   // counts cycles since an immediate shift was taken
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 8'h00;
         amt <= 4'h0;
         timed <= 1'b0;
      end else if (imm_take) begin
         cnt <= 8'h00;
         amt <= instr[6:3];
         timed <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
         timed <= timed && !op_done;
      end
   end
   sequence byte_run;
      !instr_ready ##1 op_done;
   endsequence
   property byte_left_p;
      logic [2:0] s;
      logic [15:0] v;
      (take && instr[15:3] == OP_BYTE_LEFT, s = instr[2:0], v = alu_general_register_subset[instr[2:0]])
         |=> byte_run ##1 alu_general_register_subset[s] == {v[7:0], 8'h00};
   endproperty
   property byte_right_p;
      logic [2:0] s;
      logic [15:0] v;
      (take && instr[15:3] == OP_BYTE_RIGHT, s = instr[2:0], v = alu_general_register_subset[instr[2:0]])
         |=> byte_run ##1 alu_general_register_subset[s] == {8'h00, v[15:8]};
   endproperty
   stall_mirror_a: assert property (stall_fetch == !instr_ready) else $error("stall not inverse of ready");
   done_pulse_a: assert property (op_done |=> !op_done) else $error("done longer than one cycle");
   done_release_a: assert property (op_done |-> stall_fetch ##1 instr_ready) else $error("bad release");
   byte_left_a: assert property (byte_left_p) else $error("byte left shift wrong");
   byte_right_a: assert property (byte_right_p) else $error("byte right shift wrong");
   imm_time_a: assert property (op_done && timed |-> cnt == {4'h0, amt}) else $error("wrong cycle count");
   flag_hold_a: assert property (!op_done |=> $stable(flags)) else $error("flags moved without done");
   product_hold_a: assert property ($changed({product_high_half, product_low_half}) |->
      $past(op_done) || $past(product_wr.en) || $past(rst)) else $error("product moved unasked");
endmodule // shift_unit_asserts
bind alu_shift_unit shift_unit_asserts shift_unit_asserts_inst (.clk(clk), .rst(rst),
   .instr_valid(instr_valid), .instr(instr), .reg_wr(reg_wr), .product_wr(product_wr),
   .instr_ready(instr_ready), .stall_fetch(stall_fetch), .op_done(op_done),
   .alu_general_register_subset(alu_general_register_subset), .product_high_half(product_high_half),
   .product_low_half(product_low_half), .shift_out_bit_flag(shift_out_bit_flag),
   .shift_overflow_flag(shift_overflow_flag), .precision_loss_flag(precision_loss_flag));

// >>> sim/instr_sequencer.sv
// instruction sequencer model feeding shift words
`timescale 1ns/1ps
module instr_sequencer (
   input wire logic clk,
   input wire logic instr_ready,
   output logic instr_valid,
   output logic [15:0] instr
);
   initial begin
      instr_valid = 1'b0;
      instr = 16'h0000;
   end
   task automatic issue(input logic [15:0] w, input int gap);
      repeat (gap) @(negedge clk);
      instr_valid = 1'b1;
      instr = w;
      // fetch is stalled while busy, so the word is held; ready is read settled, off the edge
      while (instr_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      instr_valid = 1'b0;
      instr = ~w;
   endtask
endmodule // instr_sequencer

// >>> sim/testbench.sv
// self-checking bench of the alu shift unit
`timescale 1ns/1ps
module testbench;
   import shift_unit_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic instr_valid, instr_ready, stall_fetch, op_done, sb, mo, ml;
   logic [15:0] instr, ph, pl;
   reg_write_t reg_wr = '0;
   product_write_t product_wr = '0;
   alu_regs_t regs;
   int miscompares = 0;
   int n_tests = 0;
   always #2.5 clk = ~clk;
   alu_shift_unit alu_shift_unit_inst (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .reg_wr(reg_wr), .product_wr(product_wr), .instr_ready(instr_ready), .stall_fetch(stall_fetch),
      .op_done(op_done), .alu_general_register_subset(regs), .product_high_half(ph), .product_low_half(pl),
      .shift_out_bit_flag(sb), .shift_overflow_flag(mo), .precision_loss_flag(ml));
   instr_sequencer instr_sequencer_inst (.clk(clk), .instr_ready(instr_ready), .instr_valid(instr_valid),
      .instr(instr));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // returns {hit, last bit out, result}
   function automatic logic [33:0] shift_ref(input logic [31:0] v, input int w, input int n, input bit left,
      input bit sg);
      logic o;
      logic h;
      o = 1'b0;
      h = 1'b0;
      for (int i = 0; i < n; i++) begin
         if (left && sg) begin
            o = v[14];
            h |= v[14] ^ v[15];
            v[14:0] = {v[13:0], 1'b0};
         end else if (left) begin
            o = v[w-1];
            h |= o;
            v = v << 1;
         end else begin
            o = v[0];
            h |= o;
            v = v >> 1;
            if (sg) v[15] = v[14];
         end
      end
      if (w == 16) v[31:16] = 16'h0000;
      return {h, o, v};
   endfunction
   task automatic put_reg(input logic [2:0] s, input logic [15:0] d);
      // the caller drops the enable once, so two writes in a row never assign it twice in one step
      reg_wr = '{en: 1'b1, sel: s, data: d};
      @(negedge clk);
   endtask
   task automatic do_case(input logic [15:0] w, input logic [31:0] v, input int n, input int cyc,
      input bit regamt, input bit prod, input bit left, input bit sg, input bit ovf);
      logic [33:0] e;
      int c;
      logic keep;
      e = shift_ref(v, prod ? 32 : 16, n, left, sg);
      if (prod) begin
         product_wr = '{en: 1'b1, high_half: v[31:16], low_half: v[15:0]};
         @(negedge clk);
         product_wr.en = 1'b0;
      end else put_reg(w[2:0], v[15:0]);
      if (regamt) put_reg(w[5:3], n[15:0]);
      reg_wr.en = 1'b0;
      keep = ovf ? ml : mo;
      instr_sequencer_inst.issue(w, n % 2);
      check("busy", 32'(stall_fetch), 32'h1);
      c = 1;
      while (op_done !== 1'b1 && c < 100) begin
         @(negedge clk);
         c++;
      end
      check("cycles", 32'(c), 32'(cyc + 1));
      @(negedge clk);
      if (prod) check("product", {ph, pl}, e[31:0]);
      else check("target", 32'(regs[w[2:0]]), e[31:0]);
      check("shift out", 32'(sb), 32'(e[32]));
      check(ovf ? "overflow" : "loss", 32'(ovf ? mo : ml), 32'(e[33]));
      check("kept flag", 32'(ovf ? ml : mo), 32'(keep));
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("idle", 32'({instr_ready, stall_fetch, op_done, sb, mo, ml}), 32'h0000_0020);
      check("idle product", {ph, pl}, 32'h0000_0000);
      check("regs", 32'(regs !== '0), 32'h0);
      instr_sequencer_inst.issue(16'h0000, 0);
      check("ignored", {instr_ready, stall_fetch}, 32'h2);
      do_case({OP_LEFT_IMM, 4'h3, 3'h2}, 32'h0000_A5F0, 3, 3, 0, 0, 1, 0, 1);
      do_case({OP_RIGHT_IMM, 4'hF, 3'h3}, 32'h0000_8001, 15, 15, 0, 0, 0, 0, 0);
      do_case({OP_SIGNED_LEFT_IMM, 4'h5, 3'h4}, 32'h0000_C3FF, 5, 5, 0, 0, 1, 1, 1);
      do_case({OP_SIGNED_RIGHT_IMM, 4'h4, 3'h5}, 32'h0000_8F0F, 4, 4, 0, 0, 0, 1, 1);
      do_case({OP_LEFT_REG, 3'h6, 3'h1}, 32'h0000_4321, 2, 2, 1, 0, 1, 0, 1);
      do_case({OP_RIGHT_REG, 3'h0, 3'h7}, 32'h0000_FFFF, 0, 0, 1, 0, 0, 0, 0);
      do_case({OP_SIGNED_LEFT_REG, 3'h1, 3'h0}, 32'h0000_9234, 7, 7, 1, 0, 1, 1, 1);
      do_case({OP_SIGNED_RIGHT_REG, 3'h2, 3'h6}, 32'h0000_8421, 20, 20, 1, 0, 0, 1, 0);
      do_case({OP_BYTE_LEFT, 3'h3}, 32'h0000_12F0, 8, 1, 0, 0, 1, 0, 1);
      do_case({OP_BYTE_RIGHT, 3'h4}, 32'h0000_34A5, 8, 1, 0, 0, 0, 0, 0);
      do_case({OP_PRODUCT_LEFT_IMM, 4'h9, PRODUCT_TAIL}, 32'h8765_4321, 9, 9, 0, 1, 1, 0, 1);
      do_case({OP_PRODUCT_RIGHT_IMM, 4'hC, PRODUCT_TAIL}, 32'h8765_4321, 12, 12, 0, 1, 0, 0, 0);
      do_case({OP_PRODUCT_RIGHT_REG, 3'h5, PRODUCT_TAIL}, 32'hF000_0F0F, 17, 17, 1, 1, 0, 0, 0);
      complete_run;
   end
   // the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      complete_run;
   end
endmodule // testbench
